/* verilog/acpc_pkg.sv */
// Purpose: shared constants for the axis command precondition checker
// Assumes: two axes, X is index 0 and Y is index 1
// Notes: error codes are the decimal numbers reported to the host
package acpc_pkg;

  // ------------------------------------------------------------
  // command encodings
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_POS_TO_SPD = 3'h1;
  localparam logic [2:0] CMD_DEC_STOP = 3'h2;
  localparam logic [2:0] CMD_POS_SYNC = 3'h3;
  localparam logic [2:0] CMD_SPD_SYNC = 3'h4;
  localparam logic [2:0] CMD_AUX_CLEAR = 3'h5;

  // ------------------------------------------------------------
  // axis indices and widths
  // ------------------------------------------------------------
  localparam int NUM_AXES = 2;
  localparam logic AXIS_X = 1'b0;
  localparam logic AXIS_Y = 1'b1;
  localparam int ERR_W = 10;
  localparam int RATIO_W = 16;

  // ------------------------------------------------------------
  // error codes and reset values
  // ------------------------------------------------------------
  localparam logic [9:0] ERR_NONE = 10'h000;
  localparam logic [9:0] ERR_PS_CIRC = 10'h139;
  localparam logic [9:0] ERR_PS_LIN = 10'h13a;
  localparam logic [9:0] ERR_PS_DECEL = 10'h13c;
  localparam logic [9:0] ERR_PS_MODE = 10'h13d;
  localparam logic [9:0] ERR_DS_JOG = 10'h142;
  localparam logic [9:0] ERR_PY_BUSY = 10'h155;
  localparam logic [9:0] ERR_PY_INH = 10'h156;
  localparam logic [9:0] ERR_PY_AUX = 10'h157;
  localparam logic [9:0] ERR_PY_ABS = 10'h158;
  localparam logic [9:0] ERR_PY_MORG = 10'h15a;
  localparam logic [9:0] ERR_PY_SELF = 10'h15b;
  localparam logic [9:0] ERR_PY_MFOL = 10'h15d;
  localparam logic [9:0] ERR_SY_MBUSY = 10'h15e;
  localparam logic [9:0] ERR_SY_BUSY = 10'h15f;
  localparam logic [9:0] ERR_SY_INH = 10'h160;
  localparam logic [9:0] ERR_SY_AUX = 10'h161;
  localparam logic [9:0] ERR_SY_SELF = 10'h163;
  localparam logic [9:0] ERR_SY_RATIO = 10'h164;

  localparam logic [1:0] AUX_RST = 2'h0;

endpackage

/* verilog/acpc_rule_eval.sv */
// Purpose: combinational precondition evaluation for one command
// Assumes: state flags are stable in the cycle the command is taken
// Notes: first failing check in priority order gives the error code
`timescale 1ns/1ps
`default_nettype none
module acpc_rule_eval (
  input wire logic [2:0] cmd,
  input wire logic axis,
  input wire logic main_axis,
  input wire logic abs_coord,
  input wire logic [acpc_pkg::RATIO_W-1:0] main_ratio,
  input wire logic [acpc_pkg::RATIO_W-1:0] fol_ratio,
  input wire logic [1:0] busy,
  input wire logic [1:0] circ_interp,
  input wire logic [1:0] lin_interp,
  input wire logic [1:0] decel,
  input wire logic [1:0] pos_or_inch,
  input wire logic [1:0] jog,
  input wire logic [1:0] out_inhibit,
  input wire logic [1:0] origin_ok,
  input wire logic [1:0] pos_follower,
  input wire logic [1:0] aux_on,
  output logic [acpc_pkg::ERR_W-1:0] err
);
  import acpc_pkg::*;

  // ------------------------------------------------------------
  // priority check chain
  // ------------------------------------------------------------
  // earlier checks hide later ones so only one code is reported
  always_comb begin
    err = ERR_NONE;
    unique case (cmd)
      CMD_POS_TO_SPD: begin
        if (circ_interp[axis]) begin
          err = ERR_PS_CIRC;
        end else if (lin_interp[axis]) begin
          err = ERR_PS_LIN;
        end else if (decel[axis]) begin
          err = ERR_PS_DECEL;
        end else if (!pos_or_inch[axis]) begin
          err = ERR_PS_MODE;
        end
      end
      CMD_DEC_STOP: begin
        if (jog[axis]) begin
          err = ERR_DS_JOG;
        end
      end
      CMD_POS_SYNC: begin
        if (busy[axis]) begin
          err = ERR_PY_BUSY;
        end else if (out_inhibit[axis]) begin
          err = ERR_PY_INH;
        end else if (aux_on[axis]) begin
          err = ERR_PY_AUX;
        end else if (abs_coord && !origin_ok[axis]) begin
          err = ERR_PY_ABS;
        end else if (main_axis == axis) begin
          err = ERR_PY_SELF;
        end else if (!origin_ok[main_axis]) begin
          err = ERR_PY_MORG;
        end else if (pos_follower[main_axis]) begin
          err = ERR_PY_MFOL;
        end
      end
      CMD_SPD_SYNC: begin
        if (busy[axis]) begin
          err = ERR_SY_BUSY;
        end else if (out_inhibit[axis]) begin
          err = ERR_SY_INH;
        end else if (aux_on[axis]) begin
          err = ERR_SY_AUX;
        end else if (main_axis == axis) begin
          err = ERR_SY_SELF;
        end else if (busy[main_axis]) begin
          err = ERR_SY_MBUSY;
        end else if (main_ratio == '0 || fol_ratio == '0) begin
          err = ERR_SY_RATIO;
        end
      end
      default: begin
        err = ERR_NONE;
      end
    endcase
  end

endmodule
`default_nettype wire

/* verilog/acpc_top.sv */
// Purpose: take host motion commands, check preconditions, accept or refuse
// Assumes: motion engine state flags are synchronous to clk
// Notes: one command per cycle; answer one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none
module acpc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_axis,
  input wire logic main_axis,
  input wire logic abs_coord,
  input wire logic [acpc_pkg::RATIO_W-1:0] main_ratio,
  input wire logic [acpc_pkg::RATIO_W-1:0] fol_ratio,
  input wire logic [1:0] busy,
  input wire logic [1:0] circ_interp,
  input wire logic [1:0] lin_interp,
  input wire logic [1:0] decel,
  input wire logic [1:0] pos_or_inch,
  input wire logic [1:0] jog,
  input wire logic [1:0] out_inhibit,
  input wire logic [1:0] origin_ok,
  input wire logic [1:0] pos_follower,
  input wire logic [1:0] aux_set,
  output logic [1:0] aux_code_on,
  output logic start_pulse,
  output logic [2:0] start_cmd,
  output logic start_axis,
  output logic start_main,
  output logic reject_pulse,
  output logic [acpc_pkg::ERR_W-1:0] err_code,
  output logic [1:0] err_axis_flag
);
  import acpc_pkg::*;

  logic [ERR_W-1:0] eval_err;
  logic [1:0] aux_q;
  logic [1:0] aux_d;
  logic start_q;
  logic start_d;
  logic [2:0] scmd_q;
  logic [2:0] scmd_d;
  logic saxis_q;
  logic saxis_d;
  logic smain_q;
  logic smain_d;
  logic rej_q;
  logic rej_d;
  logic [ERR_W-1:0] err_q;
  logic [ERR_W-1:0] err_d;
  logic [1:0] eflag_q;
  logic [1:0] eflag_d;
  logic motion_cmd;
  logic [1:0] axis_sel;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // shared by the next-state logic and the checks below
  function automatic logic is_motion(input logic [2:0] code);
    return code == CMD_POS_TO_SPD || code == CMD_DEC_STOP ||
           code == CMD_POS_SYNC || code == CMD_SPD_SYNC;
  endfunction

  // ------------------------------------------------------------
  // precondition evaluation
  // ------------------------------------------------------------
  acpc_rule_eval u_eval (
    .cmd(cmd_code),
    .axis(cmd_axis),
    .main_axis(main_axis),
    .abs_coord(abs_coord),
    .main_ratio(main_ratio),
    .fol_ratio(fol_ratio),
    .busy(busy),
    .circ_interp(circ_interp),
    .lin_interp(lin_interp),
    .decel(decel),
    .pos_or_inch(pos_or_inch),
    .jog(jog),
    .out_inhibit(out_inhibit),
    .origin_ok(origin_ok),
    .pos_follower(pos_follower),
    .aux_on(aux_q),
    .err(eval_err)
  );

  // ------------------------------------------------------------
  // next-state computation
  // ------------------------------------------------------------
  // main_axis is one bit, so only 0 (X) and 1 (Y) can be named
  always_comb begin
    motion_cmd = cmd_valid && is_motion(cmd_code);
    axis_sel = cmd_axis ? 2'h2 : 2'h1;
    // set by the engine wins over a clear in the same cycle
    aux_d = aux_q;
    if (cmd_valid && cmd_code == CMD_AUX_CLEAR) begin
      aux_d = aux_q & ~axis_sel;
    end
    aux_d = aux_d | aux_set;
    start_d = 1'b0;
    rej_d = 1'b0;
    scmd_d = scmd_q;
    saxis_d = saxis_q;
    smain_d = smain_q;
    err_d = err_q;
    eflag_d = eflag_q;
    if (motion_cmd) begin
      if (eval_err == ERR_NONE) begin
        start_d = 1'b1;
        scmd_d = cmd_code;
        saxis_d = cmd_axis;
        smain_d = main_axis;
      end else begin
        // refused: no start, previous start info kept, code latched
        rej_d = 1'b1;
        err_d = eval_err;
        eflag_d = eflag_q | axis_sel;
      end
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_q <= AUX_RST;
      start_q <= 1'b0;
      scmd_q <= CMD_NONE;
      saxis_q <= AXIS_X;
      smain_q <= AXIS_X;
      rej_q <= 1'b0;
      err_q <= ERR_NONE;
      eflag_q <= 2'h0;
    end else if (clk_en) begin
      aux_q <= aux_d;
      start_q <= start_d;
      scmd_q <= scmd_d;
      saxis_q <= saxis_d;
      smain_q <= smain_d;
      rej_q <= rej_d;
      err_q <= err_d;
      eflag_q <= eflag_d;
    end
  end

  // outputs straight from flip-flops
  assign aux_code_on = aux_q;
  assign start_pulse = start_q;
  assign start_cmd = scmd_q;
  assign start_axis = saxis_q;
  assign start_main = smain_q;
  assign reject_pulse = rej_q;
  assign err_code = err_q;
  assign err_axis_flag = eflag_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_sync_req;
    cmd_valid && clk_en && cmd_code == CMD_POS_SYNC;
  endsequence

  // switch request taken this edge
  sequence s_switch_req;
    cmd_valid && clk_en && cmd_code == CMD_POS_TO_SPD;
  endsequence

  // speed sync request taken this edge
  sequence s_speed_req;
    cmd_valid && clk_en && cmd_code == CMD_SPD_SYNC;
  endsequence

  // any of the four checked commands taken this edge
  sequence s_motion_req;
    cmd_valid && clk_en && is_motion(cmd_code);
  endsequence

  // follower clear of busy, output inhibit and aux code
  sequence s_fol_free;
    !busy[cmd_axis] && !out_inhibit[cmd_axis] && !aux_code_on[cmd_axis];
  endsequence

  // position sync past its own-axis checks, main named apart
  sequence s_py_pass;
    s_fol_free and (!(abs_coord && !origin_ok[cmd_axis]) && main_axis != cmd_axis);
  endsequence

  // speed sync past its own-axis checks, main named apart
  sequence s_sy_pass;
    s_fol_free and (main_axis != cmd_axis);
  endsequence

  chk_circ_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == CMD_POS_TO_SPD && circ_interp[cmd_axis])
    |=> (reject_pulse && err_code == ERR_PS_CIRC && !start_pulse))
    else $error("switch in circular interpolation not refused");

  chk_lin_refuse: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == CMD_POS_TO_SPD && !circ_interp[cmd_axis]
     && lin_interp[cmd_axis]) |=> (err_code == ERR_PS_LIN && reject_pulse))
    else $error("switch in linear interpolation not refused");

  chk_jog_stop: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == CMD_DEC_STOP && jog[cmd_axis])
    |=> (err_code == ERR_DS_JOG && !start_pulse))
    else $error("stop during jog not refused");

  chk_psync_busy: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and busy[cmd_axis]) |=> (err_code == ERR_PY_BUSY && reject_pulse))
    else $error("position sync on busy axis not refused");

  chk_self_main: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and (!busy[cmd_axis] && !out_inhibit[cmd_axis] && !aux_code_on[cmd_axis]
     && !(abs_coord && !origin_ok[cmd_axis]) && main_axis == cmd_axis))
    |=> (err_code == ERR_PY_SELF))
    else $error("self main axis not refused");

  chk_ratio_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == CMD_SPD_SYNC && (main_ratio == '0 || fol_ratio == '0))
    |=> !start_pulse)
    else $error("zero ratio speed sync started");

  chk_aux_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == CMD_AUX_CLEAR && !aux_set[cmd_axis])
    |=> !aux_code_on[$past(cmd_axis)])
    else $error("aux clear did not drop aux code");

  chk_err_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (!reject_pulse && !$past(reject_pulse)) |-> $stable(err_code))
    else $error("error code changed without refusal");

  chk_no_both: assert property (@(posedge clk) disable iff (!rst_b)
    !(start_pulse && reject_pulse))
    else $error("start and refusal together");

  chk_decel_switch: assert property (@(posedge clk) disable iff (!rst_b)
    (s_switch_req and (!circ_interp[cmd_axis] && !lin_interp[cmd_axis] && decel[cmd_axis]))
    |=> (reject_pulse && err_code == ERR_PS_DECEL && !start_pulse))
    else $error("switch while decelerating not refused");

  chk_mode_switch: assert property (@(posedge clk) disable iff (!rst_b)
    (s_switch_req and (!circ_interp[cmd_axis] && !lin_interp[cmd_axis] && !decel[cmd_axis]
     && !pos_or_inch[cmd_axis])) |=> (reject_pulse && err_code == ERR_PS_MODE))
    else $error("switch outside positioning or inching not refused");

  chk_switch_take: assert property (@(posedge clk) disable iff (!rst_b)
    (s_switch_req and (!circ_interp[cmd_axis] && !lin_interp[cmd_axis] && !decel[cmd_axis]
     && pos_or_inch[cmd_axis])) |=> (start_pulse && start_cmd == CMD_POS_TO_SPD))
    else $error("legal switch not started");

  chk_py_inhibit: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and (!busy[cmd_axis] && out_inhibit[cmd_axis]))
    |=> (reject_pulse && err_code == ERR_PY_INH))
    else $error("position sync under output inhibit not refused");

  chk_sy_inhibit: assert property (@(posedge clk) disable iff (!rst_b)
    (s_speed_req and (!busy[cmd_axis] && out_inhibit[cmd_axis]))
    |=> (reject_pulse && err_code == ERR_SY_INH))
    else $error("speed sync under output inhibit not refused");

  chk_py_aux: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and (!busy[cmd_axis] && !out_inhibit[cmd_axis] && aux_code_on[cmd_axis]))
    |=> (reject_pulse && err_code == ERR_PY_AUX))
    else $error("position sync with aux code on not refused");

  chk_sy_aux: assert property (@(posedge clk) disable iff (!rst_b)
    (s_speed_req and (!busy[cmd_axis] && !out_inhibit[cmd_axis] && aux_code_on[cmd_axis]))
    |=> (reject_pulse && err_code == ERR_SY_AUX))
    else $error("speed sync with aux code on not refused");

  chk_abs_origin: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and s_fol_free and (abs_coord && !origin_ok[cmd_axis]))
    |=> (reject_pulse && err_code == ERR_PY_ABS))
    else $error("absolute sync without origin not refused");

  chk_main_origin: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and s_py_pass and (!origin_ok[main_axis]))
    |=> (reject_pulse && err_code == ERR_PY_MORG))
    else $error("sync with main origin unknown not refused");

  chk_main_follow: assert property (@(posedge clk) disable iff (!rst_b)
    (s_sync_req and s_py_pass and (origin_ok[main_axis] && pos_follower[main_axis]))
    |=> (reject_pulse && err_code == ERR_PY_MFOL))
    else $error("sync on a following main axis not refused");

  chk_main_moving: assert property (@(posedge clk) disable iff (!rst_b)
    (s_speed_req and s_sy_pass and (busy[main_axis]))
    |=> (reject_pulse && err_code == ERR_SY_MBUSY))
    else $error("speed sync with moving main axis not refused");

  chk_sy_busy: assert property (@(posedge clk) disable iff (!rst_b)
    (s_speed_req and busy[cmd_axis]) |=> (reject_pulse && err_code == ERR_SY_BUSY))
    else $error("speed sync on busy axis not refused");

  chk_sy_self: assert property (@(posedge clk) disable iff (!rst_b)
    (s_speed_req and s_fol_free and (main_axis == cmd_axis))
    |=> (reject_pulse && err_code == ERR_SY_SELF))
    else $error("speed sync self main axis not refused");

  chk_ratio_code: assert property (@(posedge clk) disable iff (!rst_b)
    (s_speed_req and s_sy_pass and (!busy[main_axis] && (main_ratio == '0 || fol_ratio == '0)))
    |=> (reject_pulse && err_code == ERR_SY_RATIO))
    else $error("zero ratio speed sync wrong code");

  chk_one_answer: assert property (@(posedge clk) disable iff (!rst_b)
    s_motion_req |=> (start_pulse != reject_pulse))
    else $error("checked command without exactly one answer");

  chk_err_flag: assert property (@(posedge clk) disable iff (!rst_b)
    s_motion_req |=> (start_pulse || err_axis_flag[$past(cmd_axis)]))
    else $error("refusal did not flag its axis");

endmodule
`default_nettype wire

/* testbench/acpc_host.sv */
// Purpose: host model that issues commands to the checker
// Assumes: rnd changes just after a falling clock edge
// Notes: ratios are zero now and then, to reach the ratio refusal
`timescale 1ns/1ps
`default_nettype none
module acpc_host (
  input wire logic [63:0] rnd,
  output wire logic cmd_valid,
  output wire logic [2:0] cmd_code,
  output wire logic cmd_axis,
  output wire logic main_axis,
  output wire logic abs_coord,
  output wire logic [15:0] main_ratio,
  output wire logic [15:0] fol_ratio
);
  // ----------------------------------------
  // command fields from the random word
  // ----------------------------------------
  assign cmd_valid = rnd[0] | rnd[1];
  assign cmd_code = rnd[4:2];
  assign cmd_axis = rnd[5];
  assign main_axis = rnd[6]; // only 0 for x or 1 for y
  assign abs_coord = rnd[7];
  assign main_ratio = (rnd[11:8] == 4'h0) ? 16'h0 : rnd[27:12];
  assign fol_ratio = (rnd[31:28] == 4'h0) ? 16'h0 : rnd[47:32];
endmodule
`default_nettype wire

/* testbench/axis_command_precondition_checker_bench.sv */
// Purpose: random self-checking bench against a behavioural model
// Assumes: inputs change at the falling edge, design samples at rising
// Notes: inhibit flags are sparse and poi and org mostly set, so that commands are accepted as well
`timescale 1ns/1ps
`default_nettype none
module axis_command_precondition_checker_bench;
  import acpc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [63:0] rnd = 64'h37;
  logic [63:0] r2 = 64'h37;
  logic cmd_valid, cmd_axis, main_axis, abs_coord, clk_en;
  logic [2:0] cmd_code;
  logic [RATIO_W-1:0] main_ratio, fol_ratio;
  logic [1:0] busy, circ, lin, dec, poi, jog, inh, org, pfol, aux_set;
  logic [1:0] aux_code_on, err_axis_flag, e_aux, e_eaf;
  logic start_pulse, reject_pulse, start_axis, start_main, e_st, e_rj, e_sax, e_smn;
  logic [2:0] start_cmd, e_cmd;
  logic [ERR_W-1:0] err_code, e_err;
  int n_mismatch = 0;
  int num_checks = 0;

  always #4 clk = ~clk;

  // sparse flags; inhibit-type flags are an and of two bits, aux_set an and of three; poi and org are an or of two, so mostly set
  assign busy = r2[1:0] & r2[17:16];
  assign circ = r2[3:2] & r2[19:18];
  assign lin = r2[5:4] & r2[21:20];
  assign dec = r2[7:6] & r2[23:22];
  assign poi = r2[9:8] | r2[25:24];
  assign jog = r2[11:10] & r2[27:26];
  assign inh = r2[13:12] & r2[29:28];
  assign org = r2[15:14] | r2[31:30];
  assign pfol = r2[33:32] & r2[49:48];
  assign aux_set = r2[35:34] & r2[51:50] & r2[53:52];
  assign clk_en = |r2[62:60];

  acpc_host host (.rnd(rnd), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_axis(cmd_axis), .main_axis(main_axis), .abs_coord(abs_coord),
    .main_ratio(main_ratio), .fol_ratio(fol_ratio));

  acpc_top uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_axis(cmd_axis), .main_axis(main_axis),
    .abs_coord(abs_coord), .main_ratio(main_ratio), .fol_ratio(fol_ratio),
    .busy(busy), .circ_interp(circ), .lin_interp(lin), .decel(dec),
    .pos_or_inch(poi), .jog(jog), .out_inhibit(inh), .origin_ok(org),
    .pos_follower(pfol), .aux_set(aux_set), .aux_code_on(aux_code_on),
    .start_pulse(start_pulse), .start_cmd(start_cmd), .start_axis(start_axis),
    .start_main(start_main), .reject_pulse(reject_pulse), .err_code(err_code),
    .err_axis_flag(err_axis_flag));

  function automatic logic [63:0] xs(input logic [63:0] x);
    x ^= x << 13;
    x ^= x >> 7;
    x ^= x << 17;
    return x;
  endfunction

  // ----------------------------------------
  // expected refusal, first failing check wins
  // ----------------------------------------
  function automatic int exp_err(input int c, input int a, input int m);
    case (c)
      1: if (circ[a]) return 313; else if (lin[a]) return 314;
        else if (dec[a]) return 316; else if (!poi[a]) return 317;
      2: if (jog[a]) return 322;
      3: if (busy[a]) return 341; else if (inh[a]) return 342;
        else if (e_aux[a]) return 343; else if (abs_coord && !org[a]) return 344;
        else if (m == a) return 347; else if (!org[m]) return 346;
        else if (pfol[m]) return 349;
      4: if (busy[a]) return 351; else if (inh[a]) return 352;
        else if (e_aux[a]) return 353; else if (m == a) return 355;
        else if (busy[m]) return 350;
        else if (main_ratio == 16'h0 || fol_ratio == 16'h0) return 356;
      default: ;
    endcase
    return 0;
  endfunction

  // model state; clk_en low freezes it like the design
  always @(posedge clk or negedge rst_b) begin : model
    int e;
    if (!rst_b) begin
      {e_aux, e_eaf, e_st, e_rj, e_sax, e_smn, e_cmd, e_err} = '0;
    end else if (clk_en) begin
      e = exp_err(cmd_code, cmd_axis, main_axis);
      e_st = 1'b0;
      e_rj = 1'b0;
      if (cmd_valid && cmd_code inside {[3'h1:3'h4]}) begin
        if (e != 0) begin
          e_rj = 1'b1;
          e_err = 10'(e);
          e_eaf[cmd_axis] = 1'b1;
        end else begin
          e_st = 1'b1;
          e_cmd = cmd_code;
          e_sax = cmd_axis;
          e_smn = main_axis;
        end
      end
      e_aux = aux_set | (e_aux & ~((cmd_valid && cmd_code == 3'h5) ? 2'(1 << cmd_axis) : 2'h0));
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // compare at each falling edge, then launch the next stimulus
  task automatic run(input int n);
    repeat (n) begin
      @(negedge clk);
      chk("err_code", err_code, e_err);
      chk("err_code", err_code, e_err); // again
      chk("reject", {reject_pulse, err_axis_flag}, {e_rj, e_eaf});
      chk("start", {start_pulse, start_cmd, start_axis, start_main},
        {e_st, e_cmd, e_sax, e_smn});
      chk("aux", aux_code_on, e_aux);
      // one stream, two draws, so flags do not mirror the command bits
      rnd = xs(r2);
      r2 = xs(rnd);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence: reset, random run, reset in mid-run, random run
  initial begin
    run(10);
    rst_b = 1'b1;
    run(3000);
    $display("random phase done");
    rst_b = 1'b0;
    run(3);
    rst_b = 1'b1;
    run(3000);
    $display("mid-run reset phase done");
    summarize();
  end

  // watchdog, well past the expected 6013 cycles
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
